// File: ifp_pkg.sv
// constants and types shared by the interlock flag pin logic
package ifp_pkg;

	localparam int IFP_ADDR_W = 4;
	localparam int IFP_DATA_W = 32;
	localparam int IFP_STORE_ADDR_W = 24;
	localparam int IFP_FLAG_N = 2;

	// register offsets
	localparam logic [IFP_ADDR_W-1:0] IFP_OFS_FLAG_CTRL = 4'h0;
	localparam logic [IFP_ADDR_W-1:0] IFP_OFS_ILK_STAT = 4'h4;

	// flag_io_control field positions
	localparam int IFP_BIT_DIR0 = 1;
	localparam int IFP_BIT_OUT0 = 2;
	localparam int IFP_BIT_IN0 = 3;
	localparam int IFP_BIT_DIR1 = 5;
	localparam int IFP_BIT_OUT1 = 6;
	localparam int IFP_BIT_IN1 = 7;

	// interlock status field positions
	localparam int IFP_BIT_BUSY = 0;
	localparam int IFP_BIT_PEND = 1;
	localparam int IFP_BIT_FLAG1 = 2;

	// values after reset
	localparam logic [IFP_FLAG_N-1:0] IFP_DIR_RST = 2'h0;
	localparam logic [IFP_FLAG_N-1:0] IFP_OUT_RST = 2'h0;
	localparam logic [IFP_FLAG_N-1:0] IFP_IN_RST = 2'h0;
	localparam logic [IFP_STORE_ADDR_W-1:0] IFP_ADDR_RST = 24'h000000;
	localparam logic [IFP_DATA_W-1:0] IFP_RDATA_RST = 32'h00000000;

	// interlock direction: pin zero driven, pin one sensed
	localparam logic [IFP_FLAG_N-1:0] IFP_ILK_DIR = 2'h1;

	// cycles from a register bit change to the pin following it
	localparam int IFP_PIN_LAG_CYC = 1;

	typedef enum logic [2:0] {
		IFP_ST_IDLE = 3'b001,
		IFP_ST_SIG_LOW = 3'b010,
		IFP_ST_SIG_HIGH = 3'b100
	} ifp_seq_e;

endpackage

// File: ifp_flag_cell.sv
// one flag pin: registered drive, reset-released enable, two-stage input sampler
`timescale 1ns/100ps
`default_nettype none

module ifp_flag_cell (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic pin_i,
	input wire logic drive_en_i,
	input wire logic drive_val_i,
	output logic pin_o,
	output logic pin_oe_o,
	output logic level_o
);
	import ifp_pkg::*;

	logic drv_en;
	logic drv_val;
	logic sync_a;
	logic sync_b;
	logic next_drv_en;
	logic next_drv_val;
	logic next_sync_a;
	logic next_sync_b;

	always_comb begin
		next_drv_en = drive_en_i;
		next_drv_val = drive_val_i;
		next_sync_a = pin_i;
		next_sync_b = sync_a;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			drv_en <= 1'b0;
			drv_val <= 1'b0;
			sync_a <= 1'b0;
			sync_b <= 1'b0;
		end else begin
			drv_en <= next_drv_en;
			drv_val <= next_drv_val;
			sync_a <= next_sync_a;
			sync_b <= next_sync_b;
		end
	end

	// reset floats the pin at once, without waiting for an edge
	assign pin_oe_o = drv_en & ~sys_rst_i;
	assign pin_o = drv_val;
	assign level_o = sync_b;

endmodule
`default_nettype wire

// File: ifp_flag_ctrl.sv
// interlock flag pin controller: control register, interlocked sequences, pins
`timescale 1ns/100ps
`default_nettype none

module ifp_flag_ctrl (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [ifp_pkg::IFP_ADDR_W-1:0] reg_addr_i,
	input wire logic [ifp_pkg::IFP_DATA_W-1:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [ifp_pkg::IFP_DATA_W-1:0] reg_rdata_o,
	input wire logic ilk_load_i,
	input wire logic ilk_store_i,
	input wire logic ilk_signal_i,
	input wire logic store_stall_i,
	input wire logic [ifp_pkg::IFP_STORE_ADDR_W-1:0] store_addr_i,
	output logic [ifp_pkg::IFP_STORE_ADDR_W-1:0] store_addr_o,
	output logic store_addr_valid_o,
	output logic ilk_done_o,
	output logic ilk_flag1_o,
	input wire logic [ifp_pkg::IFP_FLAG_N-1:0] flag_pin_n_i,
	output logic [ifp_pkg::IFP_FLAG_N-1:0] flag_pin_n_o,
	output logic [ifp_pkg::IFP_FLAG_N-1:0] flag_pin_n_oe_o
);
	import ifp_pkg::*;

	logic [IFP_FLAG_N-1:0] flag_direction_select;
	logic [IFP_FLAG_N-1:0] flag_output_value;
	logic [IFP_FLAG_N-1:0] flag_input_value;
	logic [IFP_FLAG_N-1:0] next_direction;
	logic [IFP_FLAG_N-1:0] next_output;
	logic [IFP_FLAG_N-1:0] next_input;
	logic [IFP_FLAG_N-1:0] pin_level;

	ifp_seq_e seq;
	ifp_seq_e next_seq;
	logic done;
	logic next_done;
	logic flag1;
	logic next_flag1;

	logic store_pend;
	logic next_store_pend;
	logic [IFP_STORE_ADDR_W-1:0] pend_addr;
	logic [IFP_STORE_ADDR_W-1:0] next_pend_addr;
	logic [IFP_STORE_ADDR_W-1:0] addr_out;
	logic [IFP_STORE_ADDR_W-1:0] next_addr_out;
	logic addr_valid;
	logic next_addr_valid;

	logic [IFP_DATA_W-1:0] rdata;
	logic [IFP_DATA_W-1:0] next_rdata;

	logic idle;
	logic take_load;
	logic take_store;
	logic take_signal;
	logic ctrl_wr;
	logic store_req;

	function automatic logic [IFP_DATA_W-1:0] ctrl_image(
		input logic [IFP_FLAG_N-1:0] dir_v,
		input logic [IFP_FLAG_N-1:0] out_v,
		input logic [IFP_FLAG_N-1:0] in_v
	);
		logic [IFP_DATA_W-1:0] img;
		img = '0;
		img[IFP_BIT_DIR0] = dir_v[0];
		img[IFP_BIT_OUT0] = out_v[0];
		img[IFP_BIT_IN0] = in_v[0];
		img[IFP_BIT_DIR1] = dir_v[1];
		img[IFP_BIT_OUT1] = out_v[1];
		img[IFP_BIT_IN1] = in_v[1];
		return img;
	endfunction

	// one load, store or signal at a time; load wins over store, store over signal
	assign idle = (seq == IFP_ST_IDLE);
	assign take_load = idle & ilk_load_i;
	assign take_store = idle & ilk_store_i & ~ilk_load_i;
	assign take_signal = idle & ilk_signal_i & ~ilk_load_i & ~ilk_store_i;
	assign ctrl_wr = reg_we_i & (reg_addr_i == IFP_OFS_FLAG_CTRL);
	assign store_req = take_store | store_pend;

	genvar gi;
	generate
		for (gi = 0; gi < IFP_FLAG_N; gi++) begin : g_pin
			ifp_flag_cell u_cell (
				.clk_i(clk_i),
				.sys_rst_i(sys_rst_i),
				.pin_i(flag_pin_n_i[gi]),
				.drive_en_i(flag_direction_select[gi]),
				.drive_val_i(flag_output_value[gi]),
				.pin_o(flag_pin_n_o[gi]),
				.pin_oe_o(flag_pin_n_oe_o[gi]),
				.level_o(pin_level[gi])
			);
		end
	endgenerate

	// control register; an interlocked instruction overrides the direction bits and output bit zero of a write in the same cycle
	always_comb begin
		next_direction = flag_direction_select;
		next_output = flag_output_value;
		next_input = flag_input_value;
		if (ctrl_wr) begin
			next_direction[0] = reg_wdata_i[IFP_BIT_DIR0];
			next_direction[1] = reg_wdata_i[IFP_BIT_DIR1];
			next_output[0] = reg_wdata_i[IFP_BIT_OUT0];
			next_output[1] = reg_wdata_i[IFP_BIT_OUT1];
		end
		for (int i = 0; i < IFP_FLAG_N; i++) begin
			// while driven, the input bit keeps the last level seen as input
			if (!flag_direction_select[i]) begin
				next_input[i] = pin_level[i];
			end
		end
		if (take_load) begin
			next_direction = IFP_ILK_DIR;
			next_output[0] = 1'b0;
		end else if (take_store) begin
			next_direction = IFP_ILK_DIR;
			next_output[0] = 1'b1;
		end else if (take_signal) begin
			next_direction = IFP_ILK_DIR;
			next_output[0] = 1'b0;
		end else if (seq == IFP_ST_SIG_LOW) begin
			next_output[0] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		// reset is a plain sampled level, so any cycle of assertion is caught
		if (sys_rst_i) begin
			flag_direction_select <= IFP_DIR_RST;
			flag_output_value <= IFP_OUT_RST;
			flag_input_value <= IFP_IN_RST;
		end else begin
			flag_direction_select <= next_direction;
			flag_output_value <= next_output;
			flag_input_value <= next_input;
		end
	end

	// interlocked sequence: load and signal report the sampled flag one
	always_comb begin
		next_seq = seq;
		next_done = 1'b0;
		next_flag1 = flag1;
		unique case (seq)
			IFP_ST_IDLE: begin
				if (take_signal) begin
					next_seq = IFP_ST_SIG_LOW;
				end
				if (take_load) begin
					next_done = 1'b1;
					next_flag1 = pin_level[1];
				end
			end
			IFP_ST_SIG_LOW: begin
				next_seq = IFP_ST_SIG_HIGH;
			end
			IFP_ST_SIG_HIGH: begin
				next_seq = IFP_ST_IDLE;
				next_done = 1'b1;
				next_flag1 = pin_level[1];
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			seq <= IFP_ST_IDLE;
			done <= 1'b0;
			flag1 <= 1'b0;
		end else begin
			seq <= next_seq;
			done <= next_done;
			flag1 <= next_flag1;
		end
	end

	// store address: out at execute, held back while the pipeline stalls it
	always_comb begin
		next_store_pend = store_req & store_stall_i;
		next_addr_valid = store_req & ~store_stall_i;
		next_pend_addr = pend_addr;
		next_addr_out = addr_out;
		if (take_store) begin
			next_pend_addr = store_addr_i;
		end
		if (next_addr_valid) begin
			next_addr_out = take_store ? store_addr_i : pend_addr;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			store_pend <= 1'b0;
			pend_addr <= IFP_ADDR_RST;
			addr_out <= IFP_ADDR_RST;
			addr_valid <= 1'b0;
		end else begin
			store_pend <= next_store_pend;
			pend_addr <= next_pend_addr;
			addr_out <= next_addr_out;
			addr_valid <= next_addr_valid;
		end
	end

	// read port: data valid only in the cycle after the strobe, zero otherwise
	always_comb begin
		next_rdata = IFP_RDATA_RST;
		if (reg_re_i) begin
			if (reg_addr_i == IFP_OFS_FLAG_CTRL) begin
				next_rdata = ctrl_image(flag_direction_select, flag_output_value, flag_input_value);
			end else if (reg_addr_i == IFP_OFS_ILK_STAT) begin
				next_rdata[IFP_BIT_BUSY] = ~idle;
				next_rdata[IFP_BIT_PEND] = store_pend;
				next_rdata[IFP_BIT_FLAG1] = flag1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rdata <= IFP_RDATA_RST;
		end else begin
			rdata <= next_rdata;
		end
	end

	assign reg_rdata_o = rdata;
	assign store_addr_o = addr_out;
	assign store_addr_valid_o = addr_valid;
	assign ilk_done_o = done;
	assign ilk_flag1_o = flag1;

	// checks on the pins and the interlocked sequences

	property p_load_low;
		@(posedge clk_i) disable iff (sys_rst_i)
		take_load |-> ##2 (flag_pin_n_o[0] == 1'b0 && flag_pin_n_oe_o[0] && !flag_pin_n_oe_o[1]);
	endproperty
	a_load_low: assert property (p_load_low) else $error("load did not drive flag zero low");

	property p_load_flag1;
		@(posedge clk_i) disable iff (sys_rst_i)
		take_load |=> (ilk_done_o && ilk_flag1_o == $past(pin_level[1]));
	endproperty
	a_load_flag1: assert property (p_load_flag1) else $error("load did not report flag one");

	property p_store_high;
		@(posedge clk_i) disable iff (sys_rst_i)
		take_store |-> ##2 (flag_pin_n_o[0] && flag_pin_n_oe_o[0]);
	endproperty
	a_store_high: assert property (p_store_high) else $error("store did not raise flag zero");

	property p_store_addr;
		@(posedge clk_i) disable iff (sys_rst_i)
		store_req |=> (store_addr_valid_o == !$past(store_stall_i) && store_pend == $past(store_stall_i));
	endproperty
	a_store_addr: assert property (p_store_addr) else $error("store address timing wrong");

	property p_sig_pulse;
		@(posedge clk_i) disable iff (sys_rst_i)
		take_signal |-> ##2 !flag_pin_n_o[0] ##1 (flag_pin_n_o[0] && ilk_done_o);
	endproperty
	a_sig_pulse: assert property (p_sig_pulse) else $error("signal pulse on flag zero wrong");

	property p_out_follow;
		@(posedge clk_i) disable iff (sys_rst_i)
		flag_pin_n_o == $past(flag_output_value, IFP_PIN_LAG_CYC);
	endproperty
	a_out_follow: assert property (p_out_follow) else $error("flag pin does not follow output bit");

	property p_dir_follow;
		@(posedge clk_i) disable iff (sys_rst_i)
		flag_pin_n_oe_o == $past(flag_direction_select, IFP_PIN_LAG_CYC);
	endproperty
	a_dir_follow: assert property (p_dir_follow) else $error("pin enable does not follow direction");

	property p_in_capture;
		@(posedge clk_i) disable iff (sys_rst_i)
		!flag_direction_select[1] |=> flag_input_value[1] == $past(pin_level[1]);
	endproperty
	a_in_capture: assert property (p_in_capture) else $error("input bit missed sampled level");

	property p_release;
		@(posedge clk_i) disable iff (sys_rst_i)
		$fell(flag_direction_select[0]) |=> !flag_pin_n_oe_o[0] ##1 flag_input_value[0] == $past(pin_level[0]);
	endproperty
	a_release: assert property (p_release) else $error("pin not released on input select");

	property p_engage;
		@(posedge clk_i) disable iff (sys_rst_i)
		$rose(flag_direction_select[0]) |-> !flag_pin_n_oe_o[0] ##1 flag_pin_n_oe_o[0];
	endproperty
	a_engage: assert property (p_engage) else $error("pin not driven after output select");

	property p_rst_float;
		@(posedge clk_i)
		sys_rst_i |-> flag_pin_n_oe_o == 2'h0;
	endproperty
	a_rst_float: assert property (p_rst_float) else $error("flag pins driven during reset");

	property p_rst_defaults;
		@(posedge clk_i)
		$past(sys_rst_i) |-> (flag_direction_select == IFP_DIR_RST && flag_output_value == IFP_OUT_RST
			&& seq == IFP_ST_IDLE);
	endproperty
	a_rst_defaults: assert property (p_rst_defaults) else $error("state not cleared by reset");

	property p_in_hold;
		@(posedge clk_i) disable iff (sys_rst_i)
		flag_direction_select[0] |=> flag_input_value[0] == $past(flag_input_value[0]);
	endproperty
	a_in_hold: assert property (p_in_hold) else $error("input bit changed while pin driven");

	property p_sig_step;
		@(posedge clk_i) disable iff (sys_rst_i)
		(seq == IFP_ST_SIG_LOW) |=> (seq == IFP_ST_SIG_HIGH && flag_output_value[0]);
	endproperty
	a_sig_step: assert property (p_sig_step) else $error("signal sequence did not raise flag zero");

endmodule
`default_nettype wire

// File: ifp_flag_peer.sv
// far-side model sharing the two flag pins, resolving each wire's level
`timescale 1ns/100ps
`default_nettype none

module ifp_flag_peer (
	input wire logic clk_i,
	input wire logic [1:0] dut_pin_i,
	input wire logic [1:0] dut_oe_i,
	input wire logic [1:0] peer_en_i,
	input wire logic [1:0] peer_val_i,
	output logic [1:0] level_o
);
	// undriven wire flips every cycle so a stale level never passes
	logic [1:0] idle_pat = 2'h1;

	always_ff @(posedge clk_i) begin
		idle_pat <= ~idle_pat;
	end

	// peer yields whenever the device drives the pin
	always_comb begin
		for (int n = 0; n < 2; n++) begin
			level_o[n] = dut_oe_i[n] ? dut_pin_i[n] : (peer_en_i[n] ? peer_val_i[n] : idle_pat[n]);
		end
	end
endmodule
`default_nettype wire

// File: interlock_flag_pins_test.sv
// self-checking bench for the interlock flag pin controller
`timescale 1ns/100ps
`default_nettype none

module interlock_flag_pins_test;
	import ifp_pkg::*;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [IFP_ADDR_W-1:0] reg_addr_i = '0;
	logic [IFP_DATA_W-1:0] reg_wdata_i = '0;
	logic reg_we_i = 1'b0;
	logic reg_re_i = 1'b0;
	logic ilk_load_i = 1'b0;
	logic ilk_store_i = 1'b0;
	logic ilk_signal_i = 1'b0;
	logic store_stall_i = 1'b0;
	logic [IFP_STORE_ADDR_W-1:0] store_addr_i = '0;
	logic [1:0] peer_en = 2'h3;
	logic [1:0] peer_val = 2'h0;
	wire logic [IFP_DATA_W-1:0] reg_rdata_o;
	wire logic [IFP_STORE_ADDR_W-1:0] store_addr_o;
	wire logic store_addr_valid_o;
	wire logic ilk_done_o;
	wire logic ilk_flag1_o;
	wire logic [1:0] pin_lvl;
	wire logic [1:0] pin_o;
	wire logic [1:0] pin_oe;
	int n_errors = 0;
	int n_checks = 0;
	logic [31:0] seed = 32'hcb24;
	logic [31:0] v;
	logic [31:0] r;
	logic [1:0] d;
	logic [1:0] o;
	logic [23:0] a;
	int j;

	ifp_flag_ctrl uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .ilk_load_i(ilk_load_i),
		.ilk_store_i(ilk_store_i), .ilk_signal_i(ilk_signal_i), .store_stall_i(store_stall_i),
		.store_addr_i(store_addr_i), .store_addr_o(store_addr_o), .store_addr_valid_o(store_addr_valid_o),
		.ilk_done_o(ilk_done_o), .ilk_flag1_o(ilk_flag1_o), .flag_pin_n_i(pin_lvl), .flag_pin_n_o(pin_o),
		.flag_pin_n_oe_o(pin_oe));
	ifp_flag_peer peer (.clk_i(clk_i), .dut_pin_i(pin_o), .dut_oe_i(pin_oe), .peer_en_i(peer_en),
		.peer_val_i(peer_val), .level_o(pin_lvl));

	initial begin
		forever #50 clk_i = ~clk_i;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [31:0] ctrl_img(logic [1:0] dv, logic [1:0] ov, logic [1:0] iv);
		logic [31:0] m;
		m = '0;
		m[IFP_BIT_DIR0] = dv[0];
		m[IFP_BIT_OUT0] = ov[0];
		m[IFP_BIT_IN0] = iv[0];
		m[IFP_BIT_DIR1] = dv[1];
		m[IFP_BIT_OUT1] = ov[1];
		m[IFP_BIT_IN1] = iv[1];
		return m;
	endfunction

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] ad, input logic [31:0] dt);
		@(posedge clk_i);
		reg_we_i <= 1'b1;
		reg_addr_i <= ad;
		reg_wdata_i <= dt;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] ad, output logic [31:0] dt);
		@(posedge clk_i);
		reg_re_i <= 1'b1;
		reg_addr_i <= ad;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		#1 dt = reg_rdata_o;
	endtask

	// returns one step after the taking edge, where the first answer stands
	task automatic ilk(input int kind);
		@(posedge clk_i);
		ilk_load_i <= (kind == 0);
		ilk_store_i <= (kind == 1);
		ilk_signal_i <= (kind == 2);
		@(posedge clk_i);
		ilk_load_i <= 1'b0;
		ilk_store_i <= 1'b0;
		ilk_signal_i <= 1'b0;
		#1;
	endtask

	task automatic tick();
		@(posedge clk_i);
		#1;
	endtask

	initial begin
		#5000000;
		n_errors++;
		print_verdict();
	end

	initial begin
		repeat (6) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(IFP_OFS_FLAG_CTRL, r);
		chk(r & 32'h66, 32'h0);
		chk(pin_oe, 2'h0);
		rd(4'h8, r);
		chk(r, 32'h0);
		for (int i = 0; i < 8; i++) begin
			v = rnd();
			d = (i < 4) ? i[1:0] : v[1:0];
			o = v[3:2];
			peer_val <= v[5:4];
			wr(IFP_OFS_FLAG_CTRL, ctrl_img(d, o, 2'h0) | 32'hffffff11);
			tick();
			chk(pin_oe, d);
			chk(pin_o & d, o & d);
			repeat (4) @(posedge clk_i);
			rd(IFP_OFS_FLAG_CTRL, r);
			chk(r & 32'h66, ctrl_img(d, o, 2'h0));
			chk(r & ctrl_img(2'h0, 2'h0, ~d), ctrl_img(2'h0, 2'h0, v[5:4] & ~d));
		end
		// pin one back to input, else the first load senses our own drive
		wr(IFP_OFS_FLAG_CTRL, 32'h0);
		for (int i = 0; i < 2; i++) begin
			peer_val <= {i[0], 1'b0};
			repeat (4) @(posedge clk_i);
			ilk(0);
			chk(ilk_done_o, 1'b1);
			chk(ilk_flag1_o, i[0]);
			tick();
			chk({pin_oe[0], pin_o[0]}, 2'h2);
			v = rnd();
			a = v[23:0];
			store_addr_i <= a;
			store_stall_i <= (i == 1);
			ilk(1);
			chk(store_addr_valid_o, (i == 0));
			tick();
			chk({pin_oe[0], pin_o[0]}, 2'h3);
			if (i == 1) begin
				rd(IFP_OFS_ILK_STAT, r);
				chk(r, (32'h1 << IFP_BIT_PEND) | (32'h1 << IFP_BIT_FLAG1));
			end
			store_stall_i <= 1'b0;
			// an unstalled store's valid pulse is already over here
			for (j = 0; i == 1 && j < 8 && store_addr_valid_o !== 1'b1; j++) begin
				tick();
			end
			if (j == 8) begin
				n_errors++;
				print_verdict();
			end
			chk(store_addr_o, a);
			peer_val <= {~i[0], 1'b0};
			repeat (4) @(posedge clk_i);
			ilk(2);
			chk(ilk_done_o, 1'b0);
			tick();
			chk(pin_o[0], 1'b0);
			tick();
			chk(pin_o[0], 1'b1);
			chk({ilk_done_o, ilk_flag1_o}, {1'b1, ~i[0]});
			rd(IFP_OFS_ILK_STAT, r);
			chk(r, i[0] ? 32'h0 : (32'h1 << IFP_BIT_FLAG1));
		end
		wr(IFP_OFS_FLAG_CTRL, ctrl_img(2'h3, 2'h3, 2'h0));
		tick();
		chk(pin_oe, 2'h3);
		#30 sys_rst_i = 1'b1;
		#1 chk(pin_oe, 2'h0);
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(IFP_OFS_FLAG_CTRL, r);
		chk(r & 32'h66, 32'h0);
		chk(pin_oe, 2'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
